// *** spi_twowire_pkg.sv ***
// package for the serial port block with the shared two-wire interface
// assumes a 32-bit classic wishbone bus with registers in the low byte lane
package spi_twowire_pkg;

  // ****************************************
  // register map
  // ****************************************
  // printed offsets are register indices, byte address is four times the index
  localparam logic [7:0] IDX_TWOWIRE_CONTROL = 8'hE8;
  localparam logic [7:0] IDX_SERIAL_DATA = 8'hF7;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'hF8;
  localparam logic [7:0] IDX_PORT_CONFIG = 8'hF0;
  localparam logic [7:0] IDX_TWOWIRE_ADDR = 8'hF1;

  // reset values
  localparam logic [7:0] RST_SERIAL_CONTROL = 8'h04;
  localparam logic [7:0] RST_SERIAL_DATA = 8'h00;
  localparam logic [7:0] RST_TWOWIRE_CONTROL = 8'h00;
  localparam logic [6:0] RST_TWOWIRE_ADDR = 7'h50;

  // ****************************************
  // field positions
  // ****************************************
  // serial_control
  localparam int B_DONE = 7;
  localparam int B_WRITE_COLLISION_FLAG = 6;
  localparam int B_SPE = 5;
  localparam int B_MSTR = 4;
  localparam int B_CLOCK_IDLE_LEVEL = 3;
  localparam int B_CLOCK_PHASE_SELECT = 2;
  localparam int B_RATE_HI = 1;
  localparam int B_RATE_LO = 0;
  // twowire_control
  localparam int B_MDO = 7;
  localparam int B_MDE = 6;
  localparam int B_MCO = 5;
  localparam int B_MDI = 4;
  localparam int B_TW_MSTR = 3;
  localparam int B_SIE = 7;
  localparam int B_GC = 6;
  // port_config
  localparam int B_RELOC = 0;

  // ****************************************
  // codes and types
  // ****************************************
  localparam logic [1:0] IRQ_START_MATCH = 2'b00;
  localparam logic [1:0] IRQ_RESTART_MATCH = 2'b01;
  localparam logic [1:0] IRQ_USER_DATA = 2'b10;
  localparam logic [1:0] IRQ_STOP = 2'b11;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] GENERAL_CALL = 7'h00;

  // output side of a two-way pin
  typedef struct packed {
    logic o;
    logic oe;
  } pad_t;

  typedef enum logic [0:0] {SPI_IDLE = 1'b0, SPI_RUN = 1'b1} spi_st_t;
  typedef enum logic [1:0] {TW_IDLE = 2'b00, TW_ADDR = 2'b01, TW_ACK = 2'b11, TW_DATA = 2'b10} tw_st_t;

endpackage

// *** spi_twowire.sv ***
// serial port block: spi master/slave sharing its pins with a two-wire slave and software master
// assumes pin inputs synchronous to clk_i and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none

module spi_twowire
  import spi_twowire_pkg::*;
#(
  parameter int ADR_W = 10
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // shared pins: serial clock, master-in, master-out / two-wire data
  input wire logic sclk_i,
  output spi_twowire_pkg::pad_t sclk_o,
  input wire logic miso_i,
  output spi_twowire_pkg::pad_t miso_o,
  input wire logic mosi_i,
  output spi_twowire_pkg::pad_t mosi_o,
  // relocated spi pins
  input wire logic alt_sclk_i,
  output spi_twowire_pkg::pad_t alt_sclk_o,
  input wire logic alt_miso_i,
  output spi_twowire_pkg::pad_t alt_miso_o,
  input wire logic alt_mosi_i,
  output spi_twowire_pkg::pad_t alt_mosi_o,
  // slave select and two-wire event
  input wire logic ss_n_i,
  output logic twowire_irq_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rxbuf;
    logic [3:0] cnt;
    logic [3:0] div;
    logic sclk;
    logic sclk_p;
    spi_st_t st;
    logic sw_master_data_out;
    logic sw_master_data_drive_en;
    logic sw_master_clock_out;
    logic sw_master_data_in;
    logic tw_mstr;
    logic sie;
    logic gc;
    logic [1:0] code;
    logic reloc;
    logic [6:0] own;
    tw_st_t ist;
    logic [3:0] ibits;
    logic [7:0] ishift;
    logic iscl_p;
    logic isda_p;
    logic started;
    logic matched;
    logic irq;
    logic ack;
    logic [7:0] dat;
  } state_t;

  state_t r, nxt;

  // half period of the serial clock in core cycles: 1, 2, 4 or 8
  function automatic logic [3:0] half_period(input logic [1:0] rate);
    half_period = 4'h1 << rate;
  endfunction

  // ****************************************
  // pin routing
  // ****************************************
  logic serial_port_enable, master, clock_idle_level, clock_phase_select, spi_main, tw_en;
  logic s_sclk, s_in;
  assign serial_port_enable = r.ctl[B_SPE];
  assign master = r.ctl[B_MSTR];
  assign clock_idle_level = r.ctl[B_CLOCK_IDLE_LEVEL];
  assign clock_phase_select = r.ctl[B_CLOCK_PHASE_SELECT];
  // spi holds the shared pins when enabled and not relocated; two-wire gets them otherwise
  assign spi_main = serial_port_enable && !r.reloc;
  assign tw_en = !serial_port_enable || r.reloc;
  assign s_sclk = r.reloc ? alt_sclk_i : sclk_i;
  // data arriving at this end: master-in for master, master-out for slave
  assign s_in = r.reloc ? (master ? alt_miso_i : alt_mosi_i) : (master ? miso_i : mosi_i);

  // ****************************************
  // bus decode
  // ****************************************
  logic req, wr, rd, wr0;
  logic [7:0] idx;
  assign req = wb_cyc_i && wb_stb_i;
  assign idx = wb_adr_i[9:2];
  // the access commits at the edge where ack is high, as the master samples it
  assign wr = req && r.ack && wb_we_i;
  assign rd = req && r.ack && !wb_we_i;
  assign wr0 = wr && wb_sel_i[0];

  // ****************************************
  // next state
  // ****************************************
  logic tick, lead, trail, samp, shft, done_ev, busy, slave_act;
  logic [7:0] rx_n;
  logic iscl, isda, irise, ifall, istart, istop, imatch, gc_set;
  logic [7:0] rdv;

  always_comb
  begin
    nxt = r;
    // serial clock edges, made here in master mode and seen on the pin in slave mode
    slave_act = serial_port_enable && !master && !ss_n_i;
    tick = (r.st == SPI_RUN) && (r.div == 4'h0);
    if (master)
    begin
      lead = tick && (r.sclk == clock_idle_level);
      trail = tick && (r.sclk != clock_idle_level);
    end
    else
    begin
      lead = slave_act && (s_sclk != r.sclk_p) && (s_sclk != clock_idle_level);
      trail = slave_act && (s_sclk != r.sclk_p) && (s_sclk == clock_idle_level);
    end
    // sample on one edge, shift on the other; first bit is preloaded
    samp = clock_phase_select ? trail : lead;
    shft = (clock_phase_select ? lead : trail) && (r.cnt != 4'h0);
    rx_n = samp ? {r.rx[6:0], s_in} : r.rx;
    done_ev = trail && (clock_phase_select ? (r.cnt == BITS_PER_BYTE - 4'h1) : (r.cnt == BITS_PER_BYTE));
    busy = (r.st == SPI_RUN) || (r.cnt != 4'h0);
    nxt.sclk_p = s_sclk;
    nxt.rx = rx_n;
    if (samp)
      nxt.cnt = r.cnt + 4'h1;
    if (shft)
      nxt.tx = {r.tx[6:0], 1'b0};
    // a raised select aborts a partial slave byte
    if (!master && ss_n_i)
      nxt.cnt = 4'h0;
    // master divider and clock
    if (r.st == SPI_RUN)
    begin
      nxt.div = tick ? half_period(r.ctl[B_RATE_HI:B_RATE_LO]) - 4'h1 : r.div - 4'h1;
      if (tick)
        nxt.sclk = !r.sclk;
    end
    else
    begin
      nxt.sclk = clock_idle_level;
    end
    if (done_ev)
    begin
      nxt.cnt = 4'h0;
      nxt.rxbuf = rx_n;
      nxt.st = SPI_IDLE;
      nxt.sclk = clock_idle_level;
    end
    if (!serial_port_enable || !master)
      nxt.st = SPI_IDLE;

    // ---- two-wire ----
    iscl = sclk_i;
    isda = mosi_i;
    irise = iscl && !r.iscl_p;
    ifall = !iscl && r.iscl_p;
    istart = iscl && r.iscl_p && r.isda_p && !isda;
    istop = iscl && r.iscl_p && !r.isda_p && isda;
    imatch = (r.ishift[7:1] == r.own) || (r.ishift[7:1] == GENERAL_CALL);
    nxt.iscl_p = iscl;
    nxt.isda_p = isda;
    nxt.irq = 1'b0;
    gc_set = 1'b0;
    if (r.tw_mstr)
    begin
      // software master: data pin latched on the rising serial clock
      if (tw_en && irise && !r.sw_master_data_drive_en)
        nxt.sw_master_data_in = isda;
      nxt.ist = TW_IDLE;
      nxt.started = 1'b0;
      nxt.matched = 1'b0;
    end
    else if (!tw_en)
    begin
      nxt.ist = TW_IDLE;
      nxt.started = 1'b0;
      nxt.matched = 1'b0;
    end
    else if (istart)
    begin
      nxt.ist = TW_ADDR;
      nxt.ibits = 4'h0;
      nxt.started = 1'b1;
      nxt.matched = 1'b0;
      nxt.code = r.started ? IRQ_RESTART_MATCH : IRQ_START_MATCH;
    end
    else if (istop)
    begin
      if (r.matched && r.sie)
      begin
        nxt.irq = 1'b1;
        nxt.code = IRQ_STOP;
      end
      nxt.ist = TW_IDLE;
      nxt.started = 1'b0;
      nxt.matched = 1'b0;
    end
    else
    begin
      case (r.ist)
        TW_ADDR, TW_DATA:
        begin
          if (irise)
          begin
            nxt.ishift = {r.ishift[6:0], isda};
            nxt.ibits = r.ibits + 4'h1;
          end
          else if (ifall && r.ibits == BITS_PER_BYTE)
          begin
            nxt.ibits = 4'h0;
            if (r.ist == TW_DATA)
            begin
              nxt.ist = TW_ACK;
              nxt.irq = 1'b1;
              nxt.code = IRQ_USER_DATA;
              nxt.rxbuf = r.ishift;
            end
            else if (imatch)
            begin
              nxt.ist = TW_ACK;
              nxt.matched = 1'b1;
              nxt.irq = 1'b1;
              if (r.ishift[7:1] == GENERAL_CALL)
              begin
                gc_set = 1'b1;
                nxt.gc = 1'b1;
              end
            end
            else
            begin
              nxt.ist = TW_IDLE;
            end
          end
        end
        TW_ACK:
        begin
          if (ifall)
            nxt.ist = TW_DATA;
        end
        TW_IDLE:
        begin
          nxt.ibits = 4'h0;
        end
        default:
        begin
          nxt.ist = TW_IDLE;
        end
      endcase
    end

    // ---- register reads, latched in the first cycle of the access ----
    case (idx)
      IDX_SERIAL_CONTROL:
        rdv = {r.ctl[7:1], (serial_port_enable && !master) ? ss_n_i : r.ctl[B_RATE_LO]};
      IDX_SERIAL_DATA:
        rdv = r.rxbuf;
      IDX_TWOWIRE_CONTROL:
        rdv = r.tw_mstr ? {r.sw_master_data_out, r.sw_master_data_drive_en, r.sw_master_clock_out, r.sw_master_data_in, 4'h8} : {r.sie, r.gc, r.code, 4'h0};
      IDX_PORT_CONFIG:
        rdv = {7'h00, r.reloc};
      IDX_TWOWIRE_ADDR:
        rdv = {1'b0, r.own};
      default:
        rdv = 8'h00;
    endcase
    nxt.ack = req && !r.ack;
    if (req && !r.ack)
      nxt.dat = rdv;

    // ---- register writes; hardware set wins over a software clear ----
    if (wr0)
    begin
      case (idx)
        IDX_SERIAL_CONTROL:
        begin
          nxt.ctl[5:0] = wb_dat_i[5:0];
          nxt.ctl[B_DONE] = wb_dat_i[B_DONE];
          nxt.ctl[B_WRITE_COLLISION_FLAG] = wb_dat_i[B_WRITE_COLLISION_FLAG];
          // an idle clock takes the new level with the write, never resting one cycle at the old one
          if (r.st == SPI_IDLE || done_ev)
            nxt.sclk = wb_dat_i[B_CLOCK_IDLE_LEVEL];
        end
        IDX_SERIAL_DATA:
        begin
          if (busy)
          begin
            nxt.ctl[B_WRITE_COLLISION_FLAG] = 1'b1;
          end
          else
          begin
            nxt.tx = wb_dat_i[7:0];
            if (serial_port_enable && master)
            begin
              nxt.st = SPI_RUN;
              nxt.div = half_period(r.ctl[B_RATE_HI:B_RATE_LO]) - 4'h1;
            end
          end
        end
        IDX_TWOWIRE_CONTROL:
        begin
          nxt.tw_mstr = wb_dat_i[B_TW_MSTR];
          // the mode bit of the same write decides which meaning the upper bits carry
          if (wb_dat_i[B_TW_MSTR])
          begin
            nxt.sw_master_data_out = wb_dat_i[B_MDO];
            nxt.sw_master_data_drive_en = wb_dat_i[B_MDE];
            nxt.sw_master_clock_out = wb_dat_i[B_MCO];
          end
          else
          begin
            nxt.sie = wb_dat_i[B_SIE];
            nxt.gc = wb_dat_i[B_GC] || gc_set;
          end
        end
        IDX_PORT_CONFIG:
          nxt.reloc = wb_dat_i[B_RELOC];
        IDX_TWOWIRE_ADDR:
          nxt.own = wb_dat_i[6:0];
        default:
        begin
        end
      endcase
    end
    // reading the data register clears done, unless a byte ends in that cycle
    if (rd && idx == IDX_SERIAL_DATA)
      nxt.ctl[B_DONE] = 1'b0;
    if (done_ev)
      nxt.ctl[B_DONE] = 1'b1;
  end

  // ****************************************
  // registers
  // ****************************************
  // one register for all state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.ctl <= RST_SERIAL_CONTROL;
      r.tx <= RST_SERIAL_DATA;
      r.rxbuf <= RST_SERIAL_DATA;
      r.sclk <= RST_SERIAL_CONTROL[B_CLOCK_IDLE_LEVEL];
      r.own <= RST_TWOWIRE_ADDR;
      r.ist <= TW_IDLE;
      r.st <= SPI_IDLE;
      r.tw_mstr <= RST_TWOWIRE_CONTROL[B_TW_MSTR];
      r.iscl_p <= 1'b1;
      r.isda_p <= 1'b1;
    end
    else
    begin
      r <= nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  pad_t spi_sclk, spi_miso, spi_mosi, tw_sclk, tw_sda;
  // spi pads: master drives clock and master-out, slave drives master-in when selected
  always_comb
  begin
    spi_sclk = '{o: r.sclk, oe: serial_port_enable && master};
    spi_mosi = '{o: r.tx[7], oe: serial_port_enable && master};
    spi_miso = '{o: r.tx[7], oe: slave_act};
    tw_sclk = '{o: r.sw_master_clock_out, oe: tw_en && r.tw_mstr};
    tw_sda = '{o: r.sw_master_data_out, oe: tw_en && r.tw_mstr && r.sw_master_data_drive_en};
    // hardware slave pulls data low for the acknowledge bit
    if (tw_en && !r.tw_mstr && r.ist == TW_ACK)
      tw_sda = '{o: 1'b0, oe: 1'b1};
  end

  assign sclk_o = spi_main ? spi_sclk : tw_sclk;
  assign mosi_o = spi_main ? spi_mosi : tw_sda;
  assign miso_o = spi_main ? spi_miso : '{o: 1'b0, oe: 1'b0};
  assign alt_sclk_o = r.reloc ? spi_sclk : '{o: 1'b0, oe: 1'b0};
  assign alt_mosi_o = r.reloc ? spi_mosi : '{o: 1'b0, oe: 1'b0};
  assign alt_miso_o = r.reloc ? spi_miso : '{o: 1'b0, oe: 1'b0};
  assign twowire_irq_o = r.irq;
  assign wb_ack_o = r.ack;
  assign wb_dat_o = {24'h000000, r.dat};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_slave_hold;
    (serial_port_enable && !master && ss_n_i) |=> (r.cnt == 4'h0);
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("slave counted bits while deselected");

  property p_ss_readback;
    (req && !r.ack && !wb_we_i && idx == IDX_SERIAL_CONTROL && serial_port_enable && !master)
      |=> (wb_ack_o && wb_dat_o[0] == $past(ss_n_i));
  endproperty
  a_ss_readback: assert property (p_ss_readback) else $error("rate bit 0 did not show select pin");

  property p_done_set;
    done_ev |=> (r.ctl[B_DONE] && r.st == SPI_IDLE && r.cnt == 4'h0);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at byte end");

  property p_write_collision_flag;
    (wr0 && idx == IDX_SERIAL_DATA && busy)
      |=> (r.ctl[B_WRITE_COLLISION_FLAG] && r.tx == ($past(shft) ? {$past(r.tx[6:0]), 1'b0} : $past(r.tx)));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_idle_level;
    (spi_main && master && r.st == SPI_IDLE) |-> (sclk_o.oe && sclk_o.o == clock_idle_level);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("serial clock not at idle level");

  property p_rate16;
    (r.st == SPI_RUN && r.ctl[1:0] == 2'b11 && tick && !done_ev) |=> (!tick)[*7] ##1 tick;
  endproperty
  a_rate16: assert property (p_rate16) else $error("divide by 16 spacing wrong");

  property p_master_dirs;
    (spi_main && master) |-> (!miso_o.oe && mosi_o.oe && mosi_o.o == r.tx[7]);
  endproperty
  a_master_dirs: assert property (p_master_dirs) else $error("master pin directions wrong");

  property p_sw_master_sda;
    (tw_en && r.tw_mstr) |-> (mosi_o.oe == r.sw_master_data_drive_en && (!r.sw_master_data_drive_en || mosi_o.o == r.sw_master_data_out) && sclk_o.o == r.sw_master_clock_out);
  endproperty
  a_sw_master_sda: assert property (p_sw_master_sda) else $error("software master pins wrong");

  property p_gc_sticky;
    (r.gc && !(wr0 && idx == IDX_TWOWIRE_CONTROL)) |=> r.gc;
  endproperty
  a_gc_sticky: assert property (p_gc_sticky) else $error("general call flag lost");

  c_master_byte: cover property (master && done_ev);
  c_slave_byte: cover property (!master && done_ev);
  c_collision: cover property (wr0 && idx == IDX_SERIAL_DATA && busy);
  c_tw_irq: cover property (twowire_irq_o && r.code == IRQ_USER_DATA);

endmodule

`default_nettype wire

// *** spi_peer.sv ***
// far-side spi peer: slave while the block is master, master while the block is slave
// assumes resolved pin levels from the bench and the block's clock
`timescale 1ns/1ps
`default_nettype none
module spi_peer
(
  // clock and mode
  input wire logic clk_i,
  input wire logic clock_idle_level_i,
  input wire logic clock_phase_select_i,
  // resolved pin levels
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  // pin drives
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic mosi_o,
  output logic mosi_oe_o,
  output logic miso_o,
  output logic miso_oe_o,
  output logic ss_n_o
);
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic slv;
  int nb;
  realtime t_lead;
  realtime per;
  initial
  begin
    {sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, slv} = 5'h00;
    ss_n_o = 1'b1;
    tx_r = 8'h00;
    t_lead = 0;
    per = 0;
  end
  assign miso_o = tx_r[7];
  assign miso_oe_o = slv;
  // slave side follows the pin itself, so even the fastest rate is tracked
  always @(sclk_i)
    if (slv)
    begin
      if ((sclk_i != clock_idle_level_i) ^ clock_phase_select_i)
      begin
        rx_r = {rx_r[6:0], mosi_i};
        nb++;
      end
      else if (nb != 0)
        tx_r = tx_r << 1;
      if (sclk_i != clock_idle_level_i)
      begin
        per = $realtime - t_lead;
        t_lead = $realtime;
      end
    end
  task automatic load(input logic [7:0] b, input logic on);
    tx_r = b;
    rx_r = 8'h00;
    nb = 0;
    slv = on;
  endtask
  task automatic set_data(input logic v, input logic e);
    @(posedge clk_i);
    mosi_o <= v;
    mosi_oe_o <= e;
  endtask
  // two-wire far master: a line is only pulled low, a released line reads high through the pull-up
  task automatic tw_drive(input logic scl, input logic sda);
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b0;
    sclk_oe_o <= !scl;
    mosi_o <= 1'b0;
    mosi_oe_o <= !sda;
  endtask
  // master side: sel low keeps select high, to show a deselected slave ignores the clock
  task automatic xfer(input logic [7:0] b, input logic sel, input int h);
    int i;
    @(posedge clk_i);
    ss_n_o <= !sel;
    sclk_o <= clock_idle_level_i;
    sclk_oe_o <= 1'b1;
    mosi_oe_o <= 1'b1;
    mosi_o <= b[7];
    rx_r = 8'h00;
    repeat (h) @(posedge clk_i);
    for (i = 7; i >= 0; i--)
    begin
      if (clock_phase_select_i)
        mosi_o <= b[i];
      if (!clock_phase_select_i)
        rx_r = {rx_r[6:0], miso_i};
      sclk_o <= !clock_idle_level_i;
      repeat (h) @(posedge clk_i);
      if (clock_phase_select_i)
        rx_r = {rx_r[6:0], miso_i};
      else if (i > 0)
        mosi_o <= b[i-1];
      sclk_o <= clock_idle_level_i;
      repeat (h) @(posedge clk_i);
    end
    ss_n_o <= 1'b1;
    sclk_oe_o <= 1'b0;
    mosi_oe_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** spi_port_with_shared_twowire_tb_top.sv ***
// self-checking bench for the serial port block with the shared two-wire pins
// assumes the spi_peer model and register indices from the package
`timescale 1ns/1ps
`default_nettype none
module spi_port_with_shared_twowire_tb_top;
  import spi_twowire_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  pad_t sclk_p, miso_p, mosi_p, asclk_p, amiso_p, amosi_p;
  logic sclk_w, miso_w, mosi_w;
  logic clock_idle_level = 1'b0;
  logic clock_phase_select = 1'b0;
  logic p_sclk, p_sclk_e, p_mosi, p_mosi_e, p_miso, p_miso_e, p_ss_n;
  logic [7:0] q;
  logic [7:0] ctl;
  int errors = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int irqs = 0;
  int i;
  always #20 clk_i = !clk_i;
  // shared lines carry pull-ups, so a released line reads high
  assign sclk_w = sclk_p.oe ? sclk_p.o : (p_sclk_e ? p_sclk : 1'b1);
  assign mosi_w = mosi_p.oe ? mosi_p.o : (p_mosi_e ? p_mosi : 1'b1);
  assign miso_w = miso_p.oe ? miso_p.o : (p_miso_e ? p_miso : 1'b1);
  spi_twowire dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sclk_i(sclk_w), .sclk_o(sclk_p), .miso_i(miso_w), .miso_o(miso_p), .mosi_i(mosi_w),
    .mosi_o(mosi_p), .alt_sclk_i(asclk_p.oe ? asclk_p.o : 1'b1), .alt_sclk_o(asclk_p),
    .alt_miso_i(amiso_p.oe ? amiso_p.o : 1'b1), .alt_miso_o(amiso_p),
    .alt_mosi_i(amosi_p.oe ? amosi_p.o : 1'b1), .alt_mosi_o(amosi_p), .ss_n_i(p_ss_n),
    .twowire_irq_o(irq));
  spi_peer peer (.clk_i(clk_i), .clock_idle_level_i(clock_idle_level), .clock_phase_select_i(clock_phase_select), .sclk_i(sclk_w), .mosi_i(mosi_w),
    .miso_i(miso_w), .sclk_o(p_sclk), .sclk_oe_o(p_sclk_e), .mosi_o(p_mosi), .mosi_oe_o(p_mosi_e),
    .miso_o(p_miso), .miso_oe_o(p_miso_e), .ss_n_o(p_ss_n));
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, entered just after a rising edge; data taken at the ack edge
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    q = rdat[7:0];
    if (n == 16)
    begin
      errors++;
      $display("[ERR] %0t no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask
  // polls the done flag; a hung transfer leaves the later compares to fail
  task automatic wait_done();
    int n;
    for (n = 0; n < 100; n++)
    begin
      acc(1'b0, IDX_SERIAL_CONTROL, 8'h00);
      if (q[7] === 1'b1)
        break;
    end
  endtask
  // two-wire byte from the far master, then the acknowledge clock with data released
  task automatic tw_byte(input logic [7:0] b);
    int k;
    for (k = 7; k >= 0; k--)
    begin
      peer.tw_drive(1'b0, b[k]);
      peer.tw_drive(1'b1, b[k]);
    end
    peer.tw_drive(1'b0, 1'b1);
    peer.tw_drive(1'b1, 1'b1);
    chk(8'(mosi_w), 8'h00);
  endtask
  // two-wire event pulses last one cycle, so each is counted once
  always @(posedge clk_i)
    if (irq === 1'b1)
      irqs++;
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      errors++;
      summarize();
    end
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(IDX_SERIAL_CONTROL, RST_SERIAL_CONTROL);
    rd(IDX_SERIAL_DATA, RST_SERIAL_DATA);
    rd(IDX_TWOWIRE_CONTROL, RST_TWOWIRE_CONTROL);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    $display("test registers done");
    // every rate and every clock mode, with a collision in each byte
    for (i = 0; i < 4; i++)
    begin
      clock_idle_level <= i[1];
      clock_phase_select <= i[0];
      ctl = {4'h3, i[1], i[0], i[1:0]};
      wr(IDX_SERIAL_CONTROL, ctl);
      chk(8'(sclk_p), {6'h00, i[1], 1'b1});
      chk({6'h00, mosi_p.oe, miso_p.oe}, 8'h02);
      peer.load(8'hC3 ^ 8'(i), 1'b1);
      wr(IDX_SERIAL_DATA, 8'h5A + 8'(i));
      wr(IDX_SERIAL_DATA, 8'hFF);
      wait_done();
      rd(IDX_SERIAL_CONTROL, 8'hC0 | ctl);
      chk(peer.rx_r, 8'h5A + 8'(i));
      chk(8'(int'(peer.per / 40.0)), 8'(2 << i));
      rd(IDX_SERIAL_DATA, 8'hC3 ^ 8'(i));
      rd(IDX_SERIAL_CONTROL, 8'h40 | ctl);
      wr(IDX_SERIAL_CONTROL, ctl);
      rd(IDX_SERIAL_CONTROL, ctl);
      chk(8'(sclk_p.o), 8'(i[1]));
      peer.load(8'h00, 1'b0);
    end
    $display("test master done");
    for (i = 0; i < 2; i++)
    begin
      clock_idle_level <= i[0];
      clock_phase_select <= i[0];
      ctl = {4'h2, i[0], i[0], 2'b00};
      wr(IDX_SERIAL_CONTROL, ctl);
      rd(IDX_SERIAL_CONTROL, ctl | 8'h01);
      chk({5'h00, sclk_p.oe, mosi_p.oe, miso_p.oe}, 8'h00);
      wr(IDX_SERIAL_DATA, 8'h3C + 8'(i));
      peer.xfer(8'hF0, 1'b0, 4);
      rd(IDX_SERIAL_CONTROL, ctl | 8'h01);
      peer.xfer(8'h96 + 8'(i), 1'b1, 4);
      chk(peer.rx_r, 8'h3C + 8'(i));
      rd(IDX_SERIAL_CONTROL, ctl | 8'h81);
      rd(IDX_SERIAL_DATA, 8'h96 + 8'(i));
    end
    $display("test slave done");
    wr(IDX_SERIAL_CONTROL, 8'h00);
    wr(IDX_TWOWIRE_CONTROL, 8'hE8);
    chk(8'(mosi_p), 8'h03);
    chk(8'(sclk_p), 8'h03);
    wr(IDX_TWOWIRE_CONTROL, 8'h68);
    chk(8'(mosi_p), 8'h01);
    wr(IDX_TWOWIRE_CONTROL, 8'h08);
    chk(8'(mosi_p.oe), 8'h00);
    chk(8'(sclk_p), 8'h01);
    for (i = 0; i < 2; i++)
    begin
      peer.set_data(!i[0], 1'b1);
      wr(IDX_TWOWIRE_CONTROL, 8'h28);
      rd(IDX_TWOWIRE_CONTROL, {3'b001, !i[0], 4'h8});
      wr(IDX_TWOWIRE_CONTROL, 8'h08);
    end
    peer.set_data(1'b0, 1'b0);
    wr(IDX_PORT_CONFIG, 8'h01);
    wr(IDX_SERIAL_CONTROL, 8'h30);
    chk({6'h00, asclk_p.oe, amosi_p.oe}, 8'h03);
    chk(8'(sclk_p), 8'h01);
    wr(IDX_SERIAL_CONTROL, 8'h00);
    wr(IDX_PORT_CONFIG, 8'h00);
    // hardware slave: start, own address, one data byte, stop
    wr(IDX_TWOWIRE_CONTROL, 8'h80);
    peer.tw_drive(1'b1, 1'b1);
    peer.tw_drive(1'b1, 1'b0);
    tw_byte({RST_TWOWIRE_ADDR, 1'b0});
    rd(IDX_TWOWIRE_CONTROL, 8'h80);
    tw_byte(8'h3A);
    rd(IDX_TWOWIRE_CONTROL, 8'hA0);
    peer.tw_drive(1'b0, 1'b0);
    peer.tw_drive(1'b1, 1'b0);
    peer.tw_drive(1'b1, 1'b1);
    rd(IDX_SERIAL_DATA, 8'h3A);
    rd(IDX_TWOWIRE_CONTROL, 8'hB0);
    chk(8'(irqs), 8'h03);
    $display("test two-wire done");
    summarize();
  end
endmodule
`default_nettype wire
